// >>> fpm_top.sv
// flash paging and mapping control: page index, paging port, mapping control
// assumes a wishbone classic master, a cpu address tap and the e clock phase
`timescale 1ns/1ps
module fpm_top
    import fpm_pkg::*;
(
    input wire logic clk_i, // system clock
    input wire logic rst_i, // synchronous reset, high
    input wire logic wb_cyc_i, // bus cycle
    input wire logic wb_stb_i, // bus strobe
    input wire logic wb_we_i, // write enable
    input wire logic [7:0] wb_adr_i, // byte offset
    input wire logic [0:0] wb_sel_i, // byte select
    input wire logic [7:0] wb_dat_i, // write data
    output logic [7:0] wb_dat_o, // read data
    output logic wb_ack_o, // acknowledge
    input wire logic special_mode_i, // special (test) modes
    input wire fpm_pkg::fpm_mode_e mode_i, // operating mode
    input wire logic paging_port_emul_enable_i, // port emulation enable
    input wire logic e_high_i, // e clock high phase
    input wire logic page_wr_i, // single-wire page write
    input wire logic [2:0] page_wdata_i, // single-wire page data
    output logic [2:0] page_rdata_o, // single-wire page read
    input wire fpm_pkg::fpm_cpu_req_s cpu_req_i, // cpu access
    output fpm_pkg::fpm_map_res_s map_res_o, // decoded mapping
    output fpm_pkg::fpm_map_ctrl_s map_ctrl_o, // mapping control
    input wire logic [7:0] port_pin_i, // port pin levels
    output logic [7:0] port_pin_o, // port pin drive
    output logic [7:0] port_oe_o // port pin enable
);
    // ******************************
    // registers
    // ******************************
    logic [2:0] page_index_reg;
    logic [7:0] port_data_reg;
    logic [7:0] port_dir_reg;
    fpm_map_ctrl_s map_ctrl_reg;
    logic map_written_reg;
    logic ack_reg;
    logic [7:0] rdata_reg;
    fpm_cs_e cs_state_reg;
    logic [1:0] cs_count_reg;
    logic cs_ext_reg;
    logic chip_sel_n_reg;
    logic [15:0] follow_base;
    logic in_window;
    logic test_win;
    logic port_mapped;
    logic req;
    logic wr;
    logic emul_pin;
    logic external_mode;

    assign req = wb_cyc_i && wb_stb_i && !ack_reg;
    assign wr = req && wb_we_i && wb_sel_i[0];
    assign external_mode = (mode_i != FPM_MODE_SINGLE);
    // off-chip emulation hides the port registers
    assign port_mapped = !(external_mode && paging_port_emul_enable_i);
    assign emul_pin = paging_port_emul_enable_i;
    // test window only in special mode with bit set
    assign test_win = special_mode_i && map_ctrl_reg.test_window;

    // ******************************
    // bus slave
    // ******************************
    // one wait-free ack per request, dropped the next cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= req;
        end
    end

    // read data mux; unmapped offsets read zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_reg <= FPM_ZERO8;
        end else if (req) begin
            unique case (wb_adr_i)
                FPM_OFS_MAP_CTRL: rdata_reg <= map_ctrl_reg;
                FPM_OFS_PORT_DATA: rdata_reg <= port_mapped ?
                    (port_pin_i & FPM_PORT_MASK) : FPM_ZERO8;
                FPM_OFS_PORT_DIR: rdata_reg <= port_mapped ?
                    port_dir_reg : FPM_ZERO8;
                FPM_OFS_PAGE_INDEX: rdata_reg <= {5'h00, page_index_reg};
                default: rdata_reg <= FPM_ZERO8;
            endcase
        end
    end
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdata_reg;

    // ******************************
    // page index register
    // ******************************
    // bus writes and the single-wire call path both load it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            page_index_reg <= FPM_ZERO3;
        end else if (page_wr_i) begin
            page_index_reg <= page_wdata_i;
        end else if (wr && wb_adr_i == FPM_OFS_PAGE_INDEX) begin
            page_index_reg <= wb_dat_i[2:0];
        end
    end
    assign page_rdata_o = page_index_reg;

    // ******************************
    // paging port
    // ******************************
    // direction register, writable anytime while mapped
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            port_dir_reg <= FPM_ZERO8;
        end else if (wr && port_mapped && wb_adr_i == FPM_OFS_PORT_DIR) begin
            port_dir_reg <= wb_dat_i & FPM_PORT_MASK;
        end
    end

    // data register; emulation pins keep their latch untouched
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            port_data_reg <= FPM_ZERO8;
        end else if (wr && port_mapped && wb_adr_i == FPM_OFS_PORT_DATA) begin
            port_data_reg[3] <= wb_dat_i[3];
            if (!emul_pin) begin
                port_data_reg[7] <= wb_dat_i[7];
                port_data_reg[2:0] <= wb_dat_i[2:0];
            end
        end
    end

    // pin drive: emulation pins output index and select, others gpio
    always_comb begin
        port_pin_o = port_data_reg & FPM_PORT_MASK;
        port_oe_o = port_dir_reg & FPM_PORT_MASK;
        if (emul_pin) begin
            port_pin_o[2:0] = page_index_reg;
            port_pin_o[7] = chip_sel_n_reg;
            port_oe_o[2:0] = 3'h7;
            port_oe_o[7] = 1'b1;
        end
    end

    // ******************************
    // mapping control register
    // ******************************
    // write once in normal modes, any number in special modes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            map_ctrl_reg <= external_mode && mode_i != FPM_MODE_PERIPH ?
                FPM_MAP_RST_EXP : FPM_MAP_RST_SC;
            map_written_reg <= 1'b0;
        end else if (wr && wb_adr_i == FPM_OFS_MAP_CTRL &&
                     (special_mode_i || !map_written_reg)) begin
            map_ctrl_reg <= wb_dat_i;
            if (!special_mode_i) begin
                map_ctrl_reg.test_window <= 1'b0;
            end
            map_written_reg <= 1'b1;
        end else if (!special_mode_i) begin
            map_ctrl_reg.test_window <= 1'b0;
        end
    end
    assign map_ctrl_o = map_ctrl_reg;

    // ******************************
    // address decode
    // ******************************
    // follow space sits 1k above the register block
    assign follow_base = {cpu_req_i.reg_base, 11'h000} + FPM_FOLLOW_OFS;
    assign in_window = test_win ? (cpu_req_i.addr >= FPM_WIN_BASE)
        : (cpu_req_i.addr >= FPM_WIN_BASE && cpu_req_i.addr <= FPM_WIN_END);

    // flash, flash register and follow space selection
    always_comb begin
        map_res_o = '0;
        if (map_ctrl_reg.flash_enable) begin
            if (in_window) begin
                map_res_o.flash_sel = 1'b1;
                if (test_win) begin
                    // upper index bits as address bits 16:15
                    map_res_o.flash_addr = {page_index_reg[2:1],
                        cpu_req_i.addr[14:0]};
                    map_res_o.array_sel = map_ctrl_reg.upper_half_only ?
                        4'hf : 4'h1 << page_index_reg[2:1];
                end else begin
                    map_res_o.flash_addr = {page_index_reg,
                        cpu_req_i.addr[13:0]};
                    map_res_o.array_sel = 4'h1 << page_index_reg[2:1];
                end
            end else if (cpu_req_i.addr >= FPM_HIGH_BASE ||
                         (cpu_req_i.addr >= FPM_LOW_BASE &&
                          cpu_req_i.addr <= FPM_LOW_END &&
                          !map_ctrl_reg.upper_half_only)) begin
                map_res_o.flash_sel = 1'b1;
                map_res_o.array_sel = 4'h1 << FPM_FIXED_ARRAY;
                // addr bit 15 picks page 6 (low half) or page 7 (high half)
                map_res_o.flash_addr = {FPM_FIXED_PAGE_LO[2:1],
                    cpu_req_i.addr[15], cpu_req_i.addr[13:0]};
            end
            if (cpu_req_i.addr >= FPM_FREG_BASE &&
                cpu_req_i.addr <= FPM_FREG_END) begin
                map_res_o.freg_sel = 1'b1;
                map_res_o.array_sel = (test_win &&
                    map_ctrl_reg.upper_half_only) ?
                    4'hf : 4'h1 << page_index_reg[2:1];
            end
        end
        if (external_mode && mode_i != FPM_MODE_PERIPH &&
            cpu_req_i.addr[15:10] == follow_base[15:10]) begin
            map_res_o.follow_sel = 1'b1;
            map_res_o.follow_narrow = (mode_i == FPM_MODE_EXP_WIDE) &&
                map_ctrl_reg.narrow_follow_bus;
            map_res_o.stretch = map_ctrl_reg.follow_space_stretch;
        end else if (external_mode && mode_i != FPM_MODE_PERIPH &&
                     cpu_req_i.ext_access) begin
            map_res_o.stretch = map_ctrl_reg.external_stretch;
        end
    end

    // ******************************
    // emulation chip select
    // ******************************
    // low in e high for window accesses, held for external_stretch more e high phases on external ones
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cs_state_reg <= FPM_ST_IDLE;
            cs_count_reg <= FPM_ZERO2;
            cs_ext_reg <= 1'b0;
            chip_sel_n_reg <= 1'b1;
        end else begin
            unique case (cs_state_reg)
                FPM_ST_IDLE: begin
                    if (paging_port_emul_enable_i && cpu_req_i.valid &&
                        e_high_i && in_window &&
                        (map_ctrl_reg.flash_enable ||
                         cpu_req_i.ext_access)) begin
                        chip_sel_n_reg <= 1'b0;
                        cs_state_reg <= FPM_ST_HIGH;
                        cs_ext_reg <= !map_ctrl_reg.flash_enable;
                        cs_count_reg <= map_ctrl_reg.external_stretch;
                    end
                end
                FPM_ST_HIGH: begin
                    if (!e_high_i) begin
                        if (cs_ext_reg && cs_count_reg != FPM_ZERO2) begin
                            cs_state_reg <= FPM_ST_STRETCH;
                        end else begin
                            chip_sel_n_reg <= 1'b1;
                            cs_state_reg <= FPM_ST_IDLE;
                        end
                    end
                end
                FPM_ST_STRETCH: begin
                    // one count per further e high phase start
                    if (e_high_i) begin
                        cs_state_reg <= FPM_ST_HIGH;
                        cs_count_reg <= cs_count_reg - 2'h1;
                    end
                end
                default: cs_state_reg <= FPM_ST_IDLE;
            endcase
            if (!paging_port_emul_enable_i) begin
                chip_sel_n_reg <= 1'b1;
                cs_state_reg <= FPM_ST_IDLE;
            end
        end
    end
endmodule : fpm_top

// >>> fpm_pkg.sv
// package for the flash paging and mapping control block
// assumes a wishbone classic slave with 8-bit data and byte offsets
package fpm_pkg;
    // ******************************
    // register offsets
    // ******************************
    localparam logic [7:0] FPM_OFS_MAP_CTRL = 8'h13;
    localparam logic [7:0] FPM_OFS_PORT_DATA = 8'hfc;
    localparam logic [7:0] FPM_OFS_PORT_DIR = 8'hfd;
    localparam logic [7:0] FPM_OFS_PAGE_INDEX = 8'hff;

    // ******************************
    // reset values and masks
    // ******************************
    localparam logic [7:0] FPM_MAP_RST_EXP = 8'h0c;
    localparam logic [7:0] FPM_MAP_RST_SC = 8'h0d;
    localparam logic [7:0] FPM_PORT_MASK = 8'h8f;
    localparam logic [7:0] FPM_ZERO8 = 8'h00;
    localparam logic [2:0] FPM_ZERO3 = 3'h0;
    localparam logic [1:0] FPM_ZERO2 = 2'h0;

    // ******************************
    // cpu address map constants
    // ******************************
    localparam logic [15:0] FPM_WIN_BASE = 16'h8000;
    localparam logic [15:0] FPM_WIN_END = 16'hbfff;
    localparam logic [15:0] FPM_LOW_BASE = 16'h4000;
    localparam logic [15:0] FPM_LOW_END = 16'h7fff;
    localparam logic [15:0] FPM_HIGH_BASE = 16'hc000;
    localparam logic [15:0] FPM_FREG_BASE = 16'h00f4;
    localparam logic [15:0] FPM_FREG_END = 16'h00f7;
    localparam logic [15:0] FPM_FOLLOW_OFS = 16'h0400;
    localparam logic [5:0] FPM_FOLLOW_HI = 6'h3f;
    localparam logic [2:0] FPM_FIXED_PAGE_LO = 3'h6;
    localparam logic [1:0] FPM_FIXED_ARRAY = 2'h3;

    // operating modes
    typedef enum logic [1:0] {
        FPM_MODE_SINGLE = 2'h0,
        FPM_MODE_EXP_NARROW = 2'h1,
        FPM_MODE_EXP_WIDE = 2'h3,
        FPM_MODE_PERIPH = 2'h2
    } fpm_mode_e;

    // mapping control register fields
    typedef struct packed {
        logic test_window;
        logic narrow_follow_bus;
        logic [1:0] follow_space_stretch;
        logic [1:0] external_stretch;
        logic upper_half_only;
        logic flash_enable;
    } fpm_map_ctrl_s;

    // cpu access presented to the mapper
    typedef struct packed {
        logic valid;
        logic [15:0] addr;
        logic [4:0] reg_base;
        logic ext_access;
    } fpm_cpu_req_s;

    // decoded mapping result
    typedef struct packed {
        logic flash_sel;
        logic [3:0] array_sel;
        logic [16:0] flash_addr;
        logic freg_sel;
        logic follow_sel;
        logic follow_narrow;
        logic [1:0] stretch;
    } fpm_map_res_s;

    // stretch states
    typedef enum logic [1:0] {
        FPM_ST_IDLE = 2'h0,
        FPM_ST_HIGH = 2'h1,
        FPM_ST_STRETCH = 2'h3
    } fpm_cs_e;
endpackage : fpm_pkg

// >>> fpm_top_asserts.sv
// concurrent checks for the paging and mapping control block
// assumes it is bound to fpm_top and sees only that module's ports
`timescale 1ns/1ps
module fpm_top_asserts
    import fpm_pkg::*;
(
    input wire logic clk_i, // clock
    input wire logic rst_i, // reset
    input wire logic wb_cyc_i, // bus cycle
    input wire logic wb_stb_i, // bus strobe
    input wire logic wb_ack_o, // bus ack
    input wire logic special_mode_i, // special modes
    input wire logic paging_port_emul_enable_i, // emulation
    input wire logic e_high_i, // e high phase
    input wire logic page_wr_i, // wire page write
    input wire logic [2:0] page_wdata_i, // wire page data
    input wire logic [2:0] page_rdata_o, // page index
    input wire fpm_pkg::fpm_cpu_req_s cpu_req_i, // cpu access
    input wire fpm_pkg::fpm_map_res_s map_res_o, // mapping
    input wire fpm_pkg::fpm_map_ctrl_s map_ctrl_o, // control
    input wire logic [7:0] port_pin_o, // pin drive
    input wire logic [7:0] port_oe_o // pin enable
);
    // short names for the decode terms
    wire fe = map_ctrl_o.flash_enable;
    wire tw = map_ctrl_o.test_window;
    wire uh = map_ctrl_o.upper_half_only;
    wire emu = paging_port_emul_enable_i;
    wire vl = cpu_req_i.valid;
    wire [15:0] ad = cpu_req_i.addr;
    wire [3:0] arr_1h = 4'h1 << page_rdata_o[2:1];
    wire in_win = vl && (ad[15:14] == 2'b10 || (tw && ad[15]));

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // ****************
    // assertions
    // ****************
    req_ack_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not answered next cycle");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    page_wire_a: assert property (page_wr_i |=> page_rdata_o == $past(page_wdata_i))
        else $error("single wire page write lost");
    cs_idle_a: assert property (!emu && !wb_stb_i ##1 !emu |-> $stable(port_pin_o[7]))
        else $error("pin 7 moved without emulation or write");
    pix_pins_a: assert property (emu ##1 emu && $stable(page_rdata_o) |->
        port_pin_o[2:0] == page_rdata_o && (&port_oe_o[2:0]))
        else $error("index pins differ from page index");
    unused_bits_a: assert property (port_oe_o[6:4] == 3'h0 && port_pin_o[6:4] == 3'h0)
        else $error("unused port bits active");
    norm_test_a: assert property (!special_mode_i |-> !tw)
        else $error("test window set in normal mode");
    page_win_a: assert property (vl && ad[15:14] == 2'b10 && fe && !tw |->
        map_res_o.flash_sel && map_res_o.flash_addr == {page_rdata_o, ad[13:0]})
        else $error("program window address wrong");
    test_win_a: assert property (vl && ad[15] && fe && tw && !uh |->
        map_res_o.array_sel == arr_1h && map_res_o.flash_addr == {page_rdata_o[2:1], ad[14:0]})
        else $error("test window array or address wrong");
    overlap_a: assert property (vl && ad[15] && fe && tw && uh |-> map_res_o.array_sel == 4'hf)
        else $error("overlap does not select all arrays");
    upper_half_a: assert property (vl && ad[15:14] == 2'b01 && fe && uh && !tw |-> !map_res_o.flash_sel)
        else $error("low fixed flash still mapped");
    fixed_low_a: assert property (vl && ad[15:14] == 2'b01 && fe && !uh && !tw |->
        map_res_o.flash_sel && map_res_o.flash_addr == {3'h6, ad[13:0]})
        else $error("low fixed flash not page 6");
    flash_off_a: assert property (!fe |-> !map_res_o.flash_sel)
        else $error("flash selected while disabled");
    cs_low_a: assert property (emu && in_win && e_high_i && (fe || cpu_req_i.ext_access) |=> !port_pin_o[7])
        else $error("chip select not low on window access");
    cs_end_a: assert property (emu && !e_high_i && fe |=> port_pin_o[7])
        else $error("chip select low outside e high");

    // main scenarios reached
    cover property (map_res_o.array_sel == 4'hf);
    cover property (emu && !port_pin_o[7]);
    cover property (page_wr_i ##1 !page_wr_i);
endmodule : fpm_top_asserts

bind fpm_top fpm_top_asserts u_fpm_top_asserts (.*);

// >>> fpm_pin_model.sv
// far side of the paging port: pins shared with outside hardware
// assumes the bench gives the level that outside parts put on undriven pins
`timescale 1ns/1ps
module fpm_pin_model (
    input wire logic [7:0] drv_i, // block drive
    input wire logic [7:0] oe_i, // block enable
    input wire logic [7:0] ext_i, // outside level
    output logic [7:0] level_o // wire level
);
    // the block wins on every pin it drives
    assign level_o = (drv_i & oe_i) | (ext_i & ~oe_i);
endmodule : fpm_pin_model

// >>> test_flash_paging_map_control.sv
// self-checking bench for the paging and mapping control block
// assumes fpm_top, fpm_pin_model and the bound checker are compiled first
`timescale 1ns/1ps
module test_flash_paging_map_control;
    import fpm_pkg::*;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic special = 1'b0, emul = 1'b0, e_high = 1'b0, page_wr = 1'b0, ack;
    logic [0:0] sel = 1'b0;
    logic [7:0] adr = 8'h00, wdat = 8'h00, ext = 8'h00, rdat, lvl, drv, oe, q;
    logic [2:0] page_wdata = 3'h0, page_rd;
    logic [31:0] rnd = 32'hee66;
    fpm_mode_e mode = FPM_MODE_SINGLE;
    fpm_cpu_req_s req = '0;
    fpm_map_res_s res;
    fpm_map_ctrl_s ctl;
    int err_count = 0, cmp_count = 0, cyc_n = 0;

    fpm_top u_fpm_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .special_mode_i(special), .mode_i(mode),
        .paging_port_emul_enable_i(emul), .e_high_i(e_high),
        .page_wr_i(page_wr), .page_wdata_i(page_wdata), .page_rdata_o(page_rd),
        .cpu_req_i(req), .map_res_o(res), .map_ctrl_o(ctl),
        .port_pin_i(lvl), .port_pin_o(drv), .port_oe_o(oe));
    fpm_pin_model u_fpm_pin_model (.drv_i(drv), .oe_i(oe), .ext_i(ext), .level_o(lvl));

    // 25 MHz clock and hang guard
    initial forever #20 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == 5000) begin
            err_count++;
            results();
        end
    end

    // ****************
    // helpers
    // ****************
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    function automatic logic [16:0] exp_faddr(input logic [2:0] p, input logic [15:0] a, input logic t);
        return t ? {p[2:1], a[14:0]} : {p, a[13:0]};
    endfunction : exp_faddr
    function automatic logic [7:0] exp_pins(input logic [7:0] d, v, x);
        return ((v & d) | (x & ~d)) & 8'h8f;
    endfunction : exp_pins
    task automatic chk8(input logic [7:0] g, e);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk8
    task automatic chk17(input logic [16:0] g, e);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("Error at %0t: address %h expected %h", $time, g, e);
        end
    endtask : chk17
    // one classic cycle; read data lands in q
    task automatic wb(input logic w, input logic [7:0] a, d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 1'b1;
        do @(posedge clk_i); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    task automatic reset(input fpm_mode_e m, input logic s, e);
        @(posedge clk_i);
        rst_i <= 1'b1;
        mode <= m;
        special <= s;
        emul <= e;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
    endtask : reset
    task automatic results();
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : results

    // ****************
    // tests
    // ****************
    initial begin
        reset(FPM_MODE_SINGLE, 1'b0, 1'b0);
        wb(1'b0, FPM_OFS_MAP_CTRL, 8'h00); chk8(q, 8'h0d);
        wb(1'b0, FPM_OFS_PORT_DIR, 8'h00); chk8(q, 8'h00);
        wb(1'b0, FPM_OFS_PAGE_INDEX, 8'h00); chk8(q, 8'h00);
        wb(1'b1, 8'h20, 8'hff);
        wb(1'b0, 8'h20, 8'h00); chk8(q, 8'h00);
        $display("test reset values done");
        // random pages over bus and single wire
        for (int i = 0; i < 8; i++) begin
            rnd = lfsr(rnd);
            wb(1'b1, FPM_OFS_PAGE_INDEX, rnd[7:0]);
            wb(1'b0, FPM_OFS_PAGE_INDEX, 8'h00); chk8(q, {5'h0, rnd[2:0]});
            req <= {1'b1, 2'b10, rnd[21:8], 5'h0, 1'b0};
            @(negedge clk_i); chk17(res.flash_addr, exp_faddr(rnd[2:0], req.addr, 1'b0));
            @(posedge clk_i);
            page_wr <= 1'b1;
            page_wdata <= rnd[26:24];
            @(posedge clk_i);
            page_wr <= 1'b0;
            @(negedge clk_i); chk8({5'h0, page_rd}, {5'h0, rnd[26:24]});
        end
        $display("test paging done");
        wb(1'b1, FPM_OFS_MAP_CTRL, 8'h83);
        wb(1'b0, FPM_OFS_MAP_CTRL, 8'h00); chk8(q, 8'h03);
        wb(1'b1, FPM_OFS_MAP_CTRL, 8'h0d);
        wb(1'b0, FPM_OFS_MAP_CTRL, 8'h00); chk8(q, 8'h03);
        req <= {1'b1, 16'h4abc, 5'h0, 1'b0};
        @(negedge clk_i); chk8({7'h0, res.flash_sel}, 8'h00);
        rnd = lfsr(rnd);
        wb(1'b1, FPM_OFS_PORT_DIR, rnd[7:0]);
        wb(1'b1, FPM_OFS_PORT_DATA, rnd[15:8]);
        ext <= rnd[23:16];
        wb(1'b0, FPM_OFS_PORT_DIR, 8'h00); chk8(q, rnd[7:0] & 8'h8f);
        chk8(oe, rnd[7:0] & 8'h8f);
        wb(1'b0, FPM_OFS_PORT_DATA, 8'h00); chk8(q, exp_pins(rnd[7:0] & 8'h8f, rnd[15:8], rnd[23:16]));
        $display("test control and port done");
        reset(FPM_MODE_SINGLE, 1'b0, 1'b1);
        wb(1'b1, FPM_OFS_PAGE_INDEX, 8'h05);
        wb(1'b1, FPM_OFS_PORT_DATA, 8'h02);
        req <= {1'b1, 16'h8100, 5'h0, 1'b0};
        e_high <= 1'b1;
        @(negedge clk_i); chk8({5'h0, drv[2:0]}, 8'h05);
        @(posedge clk_i);
        @(negedge clk_i); chk8({7'h0, drv[7]}, 8'h00);
        @(posedge clk_i);
        e_high <= 1'b0;
        @(posedge clk_i);
        @(negedge clk_i); chk8({7'h0, drv[7]}, 8'h01);
        $display("test emulation done");
        reset(FPM_MODE_EXP_WIDE, 1'b0, 1'b1);
        wb(1'b0, FPM_OFS_MAP_CTRL, 8'h00); chk8(q, 8'h0c);
        wb(1'b1, FPM_OFS_PORT_DIR, 8'hff);
        wb(1'b0, FPM_OFS_PORT_DIR, 8'h00); chk8(q, 8'h00);
        reset(FPM_MODE_EXP_WIDE, 1'b1, 1'b0);
        wb(1'b1, FPM_OFS_MAP_CTRL, 8'h81);
        wb(1'b1, FPM_OFS_PAGE_INDEX, 8'h05);
        req <= {1'b1, 16'hc123, 5'h0, 1'b0};
        @(negedge clk_i); chk17(res.flash_addr, exp_faddr(3'h5, 16'hc123, 1'b1));
        chk8({4'h0, res.array_sel}, 8'h04);
        wb(1'b1, FPM_OFS_MAP_CTRL, 8'h83);
        @(negedge clk_i); chk8({4'h0, res.array_sel}, 8'h0f);
        wb(1'b1, FPM_OFS_MAP_CTRL, 8'h81);
        wb(1'b0, FPM_OFS_MAP_CTRL, 8'h00); chk8(q, 8'h81);
        $display("test special mode done");
        results();
    end
endmodule : test_flash_paging_map_control
